/* File: core/ets_client_source.sv */
// Client end of the transmit port: buffers a frame, then streams it out.
//
// What this block and the MAC sink do
// - 512-bit path, everything on one clock
// - First frame byte in top byte lane
// - Qualifiers count only while valid high
// - Word moves when valid and ready high
// - Hold word steady while ready low
// - Drive valid and data, await ready
// - Pass-through frames start with preamble
// - Never send frames under nine bytes
// - Valid unbroken first to last; prebuffer
// - Empty count set on last word
// - Corrupt request on last word injects error
// - Looped corrupted frame counts as malformed
// - Send nothing before lanes settled
// - Client is source, MAC is sink
// - Error block overwrites frame end block
// - Pass-through supplies full eight-byte preamble
`timescale 1ns/1ps
module ets_client_source (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   ets_stream_if.client tx,
   input wire logic pass_through_in,
   input wire logic usr_valid_in,
   input wire logic [511:0] usr_data_in,
   input wire logic usr_last_in,
   input wire logic [5:0] usr_empty_in,
   input wire logic usr_corrupt_in,
   output logic usr_ready_out,
   output logic usr_drop_out,
   output logic usr_sent_out
);

   // ************************************************************
   // Frame store
   // ************************************************************
   logic [511:0] mem [ets_pkg::FRAME_WORDS];
   logic [3:0] wr_ff;
   logic [3:0] rd_ff;
   logic [3:0] last_idx_ff;
   logic [5:0] empty_ff;
   logic corrupt_ff;
   logic pt_ff;
   logic [63:0] carry_ff;
   ets_pkg::ets_state_e state_ff;

   logic take;
   logic short_frame;
   logic full_frame;

   assign take = usr_valid_in && usr_ready_out;
   // A one-word frame with too many empty bytes is under nine bytes.
   assign short_frame = (wr_ff == ets_pkg::PTR_RST) && usr_last_in &&
      (usr_empty_in > ets_pkg::EMPTY_MAX_SHORT);
   assign full_frame = wr_ff == 4'(ets_pkg::FRAME_WORDS - 1);

   // ************************************************************
   // Output register stage toward the MAC
   // ************************************************************
   logic tx_valid_ff;
   logic [511:0] tx_data_ff;
   logic tx_first_ff;
   logic tx_last_ff;
   logic [5:0] tx_empty_ff;
   logic tx_corrupt_ff;
   logic advance;
   logic load;
   logic tail_needed;

   // A new word is loaded only once the held one has been taken.
   assign advance = !tx_valid_ff || tx.ready;
   assign load = advance &&
      ((state_ff == ets_pkg::ETS_SEND) || (state_ff == ets_pkg::ETS_TAIL));
   assign tail_needed = pt_ff && (empty_ff < ets_pkg::EMPTY_LANE);

   assign tx.valid = tx_valid_ff;
   assign tx.data = tx_data_ff;
   assign tx.first = tx_first_ff;
   assign tx.last = tx_last_ff;
   assign tx.empty = tx_empty_ff;
   assign tx.tx_corrupt_request = tx_corrupt_ff;

   // ************************************************************
   // Capture side
   // ************************************************************
   always_ff @(posedge clk_sys_in) begin
      if (take) begin
         mem[wr_ff] <= usr_data_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         usr_drop_out <= 1'b0;
      end else begin
         usr_drop_out <= take && short_frame;
      end
   end

   // ************************************************************
   // Frame sequencer
   // ************************************************************
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         state_ff <= ets_pkg::ETS_FILL;
         wr_ff <= ets_pkg::PTR_RST;
         rd_ff <= ets_pkg::PTR_RST;
         last_idx_ff <= ets_pkg::PTR_RST;
         empty_ff <= ets_pkg::EMPTY_RST;
         corrupt_ff <= 1'b0;
         pt_ff <= 1'b0;
         carry_ff <= '0;
         usr_ready_out <= 1'b0;
         usr_sent_out <= 1'b0;
      end else begin
         usr_sent_out <= 1'b0;
         case (state_ff)
            ets_pkg::ETS_FILL: begin
               usr_ready_out <= 1'b1;
               if (take) begin
                  if (short_frame) begin
                     wr_ff <= ets_pkg::PTR_RST;
                  end else if (usr_last_in || full_frame) begin
                     // An oversize frame is cut and sent as corrupted.
                     last_idx_ff <= wr_ff;
                     empty_ff <= usr_last_in ? usr_empty_in :
                        ets_pkg::EMPTY_RST;
                     corrupt_ff <= usr_corrupt_in || !usr_last_in;
                     usr_ready_out <= 1'b0;
                     state_ff <= ets_pkg::ETS_WAIT;
                  end else begin
                     wr_ff <= wr_ff + 4'h1;
                  end
               end
            end
            ets_pkg::ETS_WAIT: begin
               usr_ready_out <= 1'b0;
               rd_ff <= ets_pkg::PTR_RST;
               pt_ff <= pass_through_in;
               carry_ff <= ets_pkg::PREAMBLE;
               if (tx.lanes_settled) begin
                  state_ff <= ets_pkg::ETS_SEND;
               end
            end
            ets_pkg::ETS_SEND: begin
               if (load) begin
                  carry_ff <= mem[rd_ff][63:0];
                  rd_ff <= rd_ff + 4'h1;
                  if (rd_ff == last_idx_ff) begin
                     if (tail_needed) begin
                        state_ff <= ets_pkg::ETS_TAIL;
                     end else begin
                        state_ff <= ets_pkg::ETS_FILL;
                        wr_ff <= ets_pkg::PTR_RST;
                        usr_ready_out <= 1'b1;
                        usr_sent_out <= 1'b1;
                     end
                  end
               end
            end
            ets_pkg::ETS_TAIL: begin
               if (load) begin
                  state_ff <= ets_pkg::ETS_FILL;
                  wr_ff <= ets_pkg::PTR_RST;
                  usr_ready_out <= 1'b1;
                  usr_sent_out <= 1'b1;
               end
            end
            default: begin
               state_ff <= ets_pkg::ETS_FILL;
            end
         endcase
      end
   end

   // ************************************************************
   // Word builder
   // ************************************************************
   logic [511:0] send_data;
   logic send_last;
   logic [5:0] send_empty;

   always_comb begin
      send_data = mem[rd_ff];
      send_last = 1'b0;
      send_empty = ets_pkg::EMPTY_RST;
      if (state_ff == ets_pkg::ETS_TAIL) begin
         // Spill word: last preamble-shifted lane, rest empty.
         send_data = {carry_ff, 448'h0};
         send_last = 1'b1;
         send_empty = 6'(empty_ff + ets_pkg::EMPTY_TAIL_ADD);
      end else begin
         if (pt_ff) begin
            send_data = {carry_ff, mem[rd_ff][511:64]};
         end
         if (rd_ff == last_idx_ff && !tail_needed) begin
            send_last = 1'b1;
            send_empty = pt_ff ? 6'(empty_ff - ets_pkg::EMPTY_LANE) :
               empty_ff;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         tx_valid_ff <= 1'b0;
         tx_data_ff <= '0;
         tx_first_ff <= 1'b0;
         tx_last_ff <= 1'b0;
         tx_empty_ff <= ets_pkg::EMPTY_RST;
         tx_corrupt_ff <= 1'b0;
      end else if (load) begin
         tx_valid_ff <= 1'b1;
         tx_data_ff <= send_data;
         tx_first_ff <= (state_ff == ets_pkg::ETS_SEND) &&
            (rd_ff == ets_pkg::PTR_RST);
         tx_last_ff <= send_last;
         tx_empty_ff <= send_empty;
         tx_corrupt_ff <= send_last && corrupt_ff;
      end else if (advance) begin
         // Qualifiers drop with valid so nothing stale looks meaningful.
         tx_valid_ff <= 1'b0;
         tx_first_ff <= 1'b0;
         tx_last_ff <= 1'b0;
         tx_empty_ff <= ets_pkg::EMPTY_RST;
         tx_corrupt_ff <= 1'b0;
      end
   end

endmodule : ets_client_source

/* File: core/ets_mac_sink.sv */
// MAC end of the transmit client port: accepts words, buffers, marks errors.
`timescale 1ns/1ps
module ets_mac_sink (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   ets_stream_if.mac tx,
   input wire logic lanes_stable_in,
   input wire logic link_ready_in,
   output logic link_valid_out,
   output logic [511:0] link_data_out,
   output logic link_last_out,
   output logic link_err_block_out,
   output logic [1:0] link_sync_hdr_out,
   output logic malformed_out
);

   // ************************************************************
   // Lane-stable synchroniser
   // ************************************************************
   logic ls_meta_ff;
   logic ls_sync_ff;
   logic settled_ff;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         ls_meta_ff <= 1'b0;
         ls_sync_ff <= 1'b0;
         settled_ff <= 1'b0;
      end else begin
         ls_meta_ff <= lanes_stable_in;
         ls_sync_ff <= ls_meta_ff;
         settled_ff <= ls_sync_ff;
      end
   end

   assign tx.lanes_settled = settled_ff;

   // ************************************************************
   // Incoming word and error overwrite
   // ************************************************************
   logic ready_ff;
   logic push;
   logic pop;
   ets_pkg::ets_word_s in_word;
   logic [2:0] end_lane;

   assign tx.ready = ready_ff;
   assign push = tx.valid && ready_ff;
   assign end_lane = 3'(6'(6'h3F - tx.empty) >> 3);

   always_comb begin
      in_word.data = tx.data;
      in_word.last = tx.last;
      in_word.err = tx.last && tx.tx_corrupt_request;
      if (in_word.err) begin
         for (int i = 0; i < ets_pkg::LANES; i++) begin
            if (end_lane == 3'(i)) begin
               in_word.data[ets_pkg::DATA_W - 1 - i * ets_pkg::LANE_W -:
                  ets_pkg::LANE_W] = ets_pkg::ERR_BLOCK;
            end
         end
      end
   end

   // ************************************************************
   // Two-entry buffer, slot 0 is the head
   // ************************************************************
   ets_pkg::ets_word_s slot0_ff;
   ets_pkg::ets_word_s slot1_ff;
   logic v0_ff;
   logic v1_ff;
   logic nxt_v1;

   assign pop = v0_ff && link_ready_in;

   always_comb begin
      if (pop) begin
         nxt_v1 = v1_ff && push;
      end else begin
         nxt_v1 = v1_ff || (push && v0_ff);
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         v0_ff <= 1'b0;
         v1_ff <= 1'b0;
         ready_ff <= 1'b0;
         slot0_ff <= '0;
         slot1_ff <= '0;
      end else begin
         v1_ff <= nxt_v1;
         ready_ff <= !nxt_v1;
         if (pop) begin
            v0_ff <= v1_ff || push;
            if (v1_ff) begin
               slot0_ff <= slot1_ff;
            end else if (push) begin
               slot0_ff <= in_word;
            end
            if (v1_ff && push) begin
               slot1_ff <= in_word;
            end
         end else if (push) begin
            if (!v0_ff) begin
               v0_ff <= 1'b1;
               slot0_ff <= in_word;
            end else begin
               slot1_ff <= in_word;
            end
         end
      end
   end

   // ************************************************************
   // Loopback view: a frame carrying an error block is malformed
   // ************************************************************
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         malformed_out <= 1'b0;
      end else begin
         malformed_out <= pop && slot0_ff.err;
      end
   end

   assign link_valid_out = v0_ff;
   assign link_data_out = slot0_ff.data;
   assign link_last_out = slot0_ff.last;
   assign link_err_block_out = slot0_ff.err;
   assign link_sync_hdr_out = slot0_ff.err ? ets_pkg::ERR_SYNC_HDR : 2'h0;

endmodule : ets_mac_sink

/* File: core/ets_pkg.sv */
// Shared constants and types for the transmit client stream port.
package ets_pkg;

   // ************************************************************
   // Bus geometry
   // ************************************************************
   localparam int DATA_W = 512;
   localparam int EMPTY_W = 6;
   localparam int LANE_W = 64;
   localparam int LANES = 8;
   localparam int LANE_BYTES = 8;

   // ************************************************************
   // Frame rules
   // ************************************************************
   // Largest empty count of a one-word frame still nine bytes long.
   localparam logic [5:0] EMPTY_MAX_SHORT = 6'h37;
   localparam logic [5:0] EMPTY_LANE = 6'h08;
   localparam logic [5:0] EMPTY_TAIL_ADD = 6'h38;
   localparam int FRAME_WORDS = 16;
   localparam int PTR_W = 4;

   // ************************************************************
   // Preamble and error block
   // ************************************************************
   localparam logic [63:0] PREAMBLE = 64'hFB55_5555_5555_55D5;
   localparam logic [7:0] ERR_CHAR = 8'h1E;
   localparam logic [1:0] ERR_SYNC_HDR = 2'h2;
   localparam logic [63:0] ERR_BLOCK = {8{ERR_CHAR}};

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [5:0] EMPTY_RST = 6'h00;
   localparam logic [3:0] PTR_RST = 4'h0;

   typedef struct packed {
      logic [511:0] data;
      logic last;
      logic err;
   } ets_word_s;

   typedef enum logic [1:0] {
      ETS_FILL = 2'b00,
      ETS_WAIT = 2'b01,
      ETS_SEND = 2'b10,
      ETS_TAIL = 2'b11
   } ets_state_e;

endpackage : ets_pkg

/* File: core/ets_stream_if.sv */
// Packet stream interface between client source and MAC sink.
`timescale 1ns/1ps
interface ets_stream_if;
   logic valid;
   logic ready;
   logic [511:0] data;
   logic first;
   logic last;
   logic [5:0] empty;
   logic tx_corrupt_request;
   logic lanes_settled;

   modport mac (
      input valid,
      input data,
      input first,
      input last,
      input empty,
      input tx_corrupt_request,
      output ready,
      output lanes_settled
   );

   modport client (
      output valid,
      output data,
      output first,
      output last,
      output empty,
      output tx_corrupt_request,
      input ready,
      input lanes_settled
   );
endinterface : ets_stream_if

/* File: verif/ets_stream_properties.sv */
// Concurrent checks on the client to MAC stream interface.
`timescale 1ns/1ps
module ets_stream_properties (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic valid,
   input wire logic ready,
   input wire logic [511:0] data,
   input wire logic first,
   input wire logic last,
   input wire logic [5:0] empty,
   input wire logic tx_corrupt_request,
   input wire logic lanes_settled
);
   // ************************************************************
   // Stream properties
   // ************************************************************
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);

   property p_hold;
      valid && !ready |=> valid && $stable(data)
         && $stable({first, last, empty, tx_corrupt_request});
   endproperty
   a_hold: assert property (p_hold)
      else $error("word changed while refused");

   property p_no_gap;
      valid && !last |=> valid;
   endproperty
   a_no_gap: assert property (p_no_gap)
      else $error("gap inside a frame");

   property p_start;
      $rose(valid) |-> first;
   endproperty
   a_start: assert property (p_start)
      else $error("frame began without first");

   property p_frame_end;
      valid && last && ready |=> !valid [*2];
   endproperty
   a_frame_end: assert property (p_frame_end)
      else $error("frames closer than two cycles");

   property p_settled;
      !lanes_settled |-> !valid;
   endproperty
   a_settled: assert property (p_settled)
      else $error("word sent before lanes settled");

   property p_empty_zero;
      valid && !last |-> empty == 6'h00;
   endproperty
   a_empty_zero: assert property (p_empty_zero)
      else $error("empty count outside last word");

   property p_idle;
      !valid |-> !first && !last && !tx_corrupt_request;
   endproperty
   a_idle: assert property (p_idle)
      else $error("qualifier raised while idle");

   property p_short;
      valid && first && last |-> empty <= 6'h37;
   endproperty
   a_short: assert property (p_short)
      else $error("frame shorter than nine bytes");
endmodule : ets_stream_properties

/* File: verif/testbench.sv */
// Self-checking bench joining the client source and the MAC sink.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
n_errors++; $display("wrong value %s exp %0h got %0h", nm, exp, got); end end
module testbench;
   // ************************************************************
   // Harness
   // ************************************************************
   logic clk_sys_in, rst_in, lanes_stable, link_ready, pass_through;
   logic usr_valid, usr_last, usr_corrupt, usr_ready, usr_drop, usr_sent;
   logic [511:0] usr_data, link_data;
   logic [5:0] usr_empty;
   logic link_valid, link_last, link_err, malformed;
   logic [1:0] link_sync;
   int n_errors = 0;
   int n_tests = 0;
   int n_mal = 0;
   int n_drop = 0;
   int n_sent = 0;
   logic [511:0] iq[$], lq[$];
   logic [8:0] im[$];
   logic [3:0] lm[$];
   ets_stream_if tx_if ();
   ets_mac_sink ets_mac_sink_inst (.clk_sys_in(clk_sys_in),
      .rst_in(rst_in), .tx(tx_if.mac), .lanes_stable_in(lanes_stable),
      .link_ready_in(link_ready), .link_valid_out(link_valid),
      .link_data_out(link_data), .link_last_out(link_last),
      .link_err_block_out(link_err), .link_sync_hdr_out(link_sync),
      .malformed_out(malformed));
   ets_client_source ets_client_source_inst (.clk_sys_in(clk_sys_in),
      .rst_in(rst_in), .tx(tx_if.client), .pass_through_in(pass_through),
      .usr_valid_in(usr_valid), .usr_data_in(usr_data),
      .usr_last_in(usr_last), .usr_empty_in(usr_empty),
      .usr_corrupt_in(usr_corrupt), .usr_ready_out(usr_ready),
      .usr_drop_out(usr_drop), .usr_sent_out(usr_sent));
   ets_stream_properties ets_stream_properties_inst (.clk_sys_in(clk_sys_in),
      .rst_in(rst_in), .valid(tx_if.valid), .ready(tx_if.ready),
      .data(tx_if.data), .first(tx_if.first), .last(tx_if.last),
      .empty(tx_if.empty), .tx_corrupt_request(tx_if.tx_corrupt_request),
      .lanes_settled(tx_if.lanes_settled));

   initial begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end

   // Records every word that crosses the stream and leaves the link side.
   always @(posedge clk_sys_in) begin
      if (tx_if.valid && tx_if.ready) begin
         iq.push_back(tx_if.data);
         im.push_back({tx_if.first, tx_if.last, tx_if.tx_corrupt_request,
                       tx_if.empty});
      end
      if (link_valid && link_ready) begin
         lq.push_back(link_data);
         lm.push_back({link_last, link_err, link_sync});
      end
      if (malformed) n_mal++;
      if (usr_drop) n_drop++;
      if (usr_sent) n_sent++;
   end

   // ************************************************************
   // Tasks
   // ************************************************************
   function automatic logic [511:0] wd(input int fr, input int i);
      return {8{fr[31:0], i[31:0]}};
   endfunction : wd

   task automatic send(input int fr, input int n, input logic [5:0] emp,
                       input logic cor);
      int k;
      for (int i = 0; i < n; i++) begin
         usr_valid <= 1'b1;
         usr_data <= wd(fr, i);
         usr_last <= (i == n - 1);
         usr_empty <= (i == n - 1) ? emp : 6'h00;
         usr_corrupt <= (i == n - 1) && cor;
         k = 0;
         do begin
            @(posedge clk_sys_in);
            k++;
         end while (usr_ready !== 1'b1 && k < 300);
      end
      usr_valid <= 1'b0;
      usr_last <= 1'b0;
      usr_corrupt <= 1'b0;
   endtask : send

   task automatic settle(input int n);
      int k;
      k = 0;
      while (lq.size() < n && k < 300) begin
         @(posedge clk_sys_in);
         k++;
      end
      repeat (4) @(posedge clk_sys_in);
   endtask : settle

   task automatic flush();
      iq.delete();
      im.delete();
      lq.delete();
      lm.delete();
      n_mal = 0;
      n_sent = 0;
   endtask : flush

   task automatic chk(input int fr, input int n, input logic [5:0] emp,
                      input logic cor);
      logic [511:0] e;
      logic [8:0] f;
      logic [3:0] g;
      logic lst;
      int lane;
      logic [511:0] gd;
      logic [8:0] gm;
      logic [3:0] gl;
      settle(n);
      `CHK("words in", n, iq.size())
      `CHK("words out", n, lq.size())
      for (int i = 0; i < n && iq.size() > 0 && lq.size() > 0; i++) begin
         lst = (i == n - 1);
         e = wd(fr, i);
         f = {i == 0, lst, lst && cor, lst ? emp : 6'h00};
         gd = iq.pop_front();
         `CHK("data in", e, gd)
         gm = im.pop_front();
         `CHK("flags in", f, gm)
         lane = (63 - emp) >> 3;
         if (lst && cor) e[511 - 64 * lane -: 64] = ets_pkg::ERR_BLOCK;
         g = {lst, lst && cor, (lst && cor) ? ets_pkg::ERR_SYNC_HDR : 2'h0};
         gd = lq.pop_front();
         `CHK("data out", e, gd)
         gl = lm.pop_front();
         `CHK("flags out", g, gl)
      end
      `CHK("malformed", cor ? 1 : 0, n_mal)
      `CHK("sent", 1, n_sent)
      n_mal = 0;
      n_sent = 0;
      $display("test frame %0d done", fr);
   endtask : chk

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      logic [5:0] emps[3];
      logic [511:0] e;
      emps = '{6'h00, 6'h09, 6'h3F};
      rst_in = 1'b1;
      lanes_stable = 1'b0;
      link_ready = 1'b1;
      pass_through = 1'b0;
      usr_valid = 1'b0;
      usr_data = '0;
      usr_last = 1'b0;
      usr_empty = 6'h00;
      usr_corrupt = 1'b0;
      repeat (10) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      send(1, 3, 6'h05, 1'b0);
      repeat (10) @(posedge clk_sys_in);
      `CHK("before settle", 0, iq.size())
      lanes_stable <= 1'b1;
      chk(1, 3, 6'h05, 1'b0);
      for (int j = 0; j < 3; j++) begin
         send(2 + j, 2, emps[j], 1'b1);
         chk(2 + j, 2, emps[j], 1'b1);
      end
      link_ready <= 1'b0;
      send(5, 5, 6'h00, 1'b0);
      repeat (20) @(posedge clk_sys_in);
      `CHK("stalled", 2, iq.size())
      link_ready <= 1'b1;
      chk(5, 5, 6'h00, 1'b0);
      pass_through <= 1'b1;
      send(7, 2, 6'h04, 1'b0);
      settle(3);
      e = wd(7, 0);
      `CHK("words pt", 3, iq.size())
      `CHK("preamble", ets_pkg::PREAMBLE, iq[0][511:448])
      `CHK("shifted", e[511:64], iq[0][447:0])
      `CHK("pt empty", 6'h3C, im[2][5:0])
      flush();
      pass_through <= 1'b0;
      $display("test pass-through done");
      send(10, 17, 6'h00, 1'b0);
      settle(17);
      `CHK("cut words", 17, iq.size())
      `CHK("cut end", 9'h0C0, im[15])
      `CHK("cut next", 9'h180, im[16])
      `CHK("cut block", ets_pkg::ERR_BLOCK, lq[15][63:0])
      `CHK("cut flags", 4'hE, lm[15])
      `CHK("cut malformed", 1, n_mal)
      `CHK("cut sent", 2, n_sent)
      flush();
      $display("test oversize frame done");
      send(8, 1, 6'h38, 1'b0);
      repeat (10) @(posedge clk_sys_in);
      `CHK("dropped", 1, n_drop)
      `CHK("nothing sent", 0, iq.size())
      `CHK("no sent pulse", 0, n_sent)
      $display("test short frame done");
      send(9, 1, 6'h37, 1'b0);
      chk(9, 1, 6'h37, 1'b0);
      summarize();
   end

   initial begin
      repeat (20000) @(posedge clk_sys_in);
      n_errors++;
      summarize();
   end
endmodule : testbench
